// ===== include/ppp_pkg.sv
/*
  constants for the parallel programming port: commands, action codes,
  memory geometry and programming times.
  assumes a 250 MHz core clock.
*/
package ppp_pkg;
  localparam int CLK_MHZ = 250;
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam int FLASH_PAGE_WORDS = 32;
  localparam int FLASH_WORDS = 4096;
  localparam int EE_PAGE_BYTES = 4;
  localparam int EE_BYTES = 64;
  localparam logic [7:0] FUSE_LOW_RST = 8'hFF;
  localparam logic [7:0] FUSE_HIGH_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam int PROG_TIME_US = 4;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam logic [15:0] RESET_WORD = 16'hFFFF;
endpackage

// ===== hdl/ppp_port.sv
/*
  parallel programming port: command/address/data loading, page buffers,
  self-timed flash, eeprom and fuse programming, and read-back.
  assumes all pins arrive asynchronously; all but resetn are synchronised here.
*/
// Overview of operation
// - action 10 with load strobe rising captures command byte
// - action 00, byte select 0: strobe captures low address byte
// - action 00, byte select 1: strobe captures high address byte
// - action 01: strobe captures data low or high byte by byte select
// - command 10h selects flash page write
// - page latch pulse with byte select 1 stores data at low address word
// - low address bits pick word, higher bits pick page
// - write pulse programs buffered page, ready low until done
// - no-operation command resets internal write controls
// - command 11h fills eeprom buffer; write with select 0 programs it
// - command 02h, output enable low: flash low/high byte on data bus
// - command 03h, output enable low, select 0: eeprom byte on bus
// - command 40h: low data byte written to fuses on write pulse
// - select 1, extended 0 during fuse write targets high fuse
// - select 0, extended 1 during fuse write targets extended fuse
// - ready low while programming, high when ready for commands
// - data bus driven only while output enable is low
// - command and address retained across operations
`timescale 1ns/10ps
module ppp_port #(
  parameter int PROG_CYCLES = ppp_pkg::PROG_CYCLES
) (
  input wire logic ref_clk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic action_select_hi, // action bit 1
  input wire logic action_select_lo, // action bit 0
  input wire logic byte_select_low_high, // 0 low byte, 1 high byte
  input wire logic byte_select_extended, // extended byte select
  input wire logic page_latch_strobe, // page latch, active high
  input wire logic load_strobe, // load strobe, active high
  input wire logic write_n, // write pulse, active low
  input wire logic output_enable_n, // output enable, active low
  input wire logic [7:0] data_in, // data bus input
  output logic [7:0] data_out, // data bus output
  output logic data_oe, // data bus drive enable
  output logic ready_busy_flag // 1 ready, 0 busy
);
  localparam int FW = $clog2(ppp_pkg::FLASH_WORDS);
  localparam int FPW = $clog2(ppp_pkg::FLASH_PAGE_WORDS);
  localparam int EW = $clog2(ppp_pkg::EE_BYTES);
  localparam int EPW = $clog2(ppp_pkg::EE_PAGE_BYTES);
  localparam int CW = $clog2(PROG_CYCLES + 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FLASH = 2'b01,
    ST_EE = 2'b10,
    ST_FUSE = 2'b11
  } ppp_state_e;

  logic [7:0] s1_q, s2_q;
  logic [7:0] d1_q, d2_q;
  logic ld_prev_q, pl_prev_q, wr_prev_q;
  logic [7:0] cmd_q, addr_lo_q, addr_hi_q, dlo_q, dhi_q;
  logic [7:0] fuse_lo_q, fuse_hi_q, fuse_ext_q;
  logic [15:0] flash_mem [ppp_pkg::FLASH_WORDS];
  logic [7:0] ee_mem [ppp_pkg::EE_BYTES];
  logic [15:0] fbuf [ppp_pkg::FLASH_PAGE_WORDS];
  logic [7:0] ebuf [ppp_pkg::EE_PAGE_BYTES];
  logic [ppp_pkg::FLASH_PAGE_WORDS-1:0] fvalid_q;
  logic [ppp_pkg::EE_PAGE_BYTES-1:0] evalid_q;
  ppp_state_e st_q;
  logic [CW-1:0] cnt_q;
  logic [1:0] fuse_sel_q;
  logic busy;

  // two-flop synchronisers for every pin except resetn
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 8'hC0;
      s2_q <= 8'hC0;
      d1_q <= 8'h00;
      d2_q <= 8'h00;
    end else begin
      s1_q <= {output_enable_n, write_n, action_select_hi, action_select_lo,
               byte_select_low_high, byte_select_extended, page_latch_strobe, load_strobe};
      s2_q <= s1_q;
      d1_q <= data_in;
      d2_q <= d1_q;
    end
  end

  wire oe_n = s2_q[7];
  wire wr_n = s2_q[6];
  wire [1:0] act = s2_q[5:4];
  wire sel_hi = s2_q[3];
  wire sel_ext = s2_q[2];
  wire pl = s2_q[1];
  wire ld = s2_q[0];
  wire ld_rise = ld && !ld_prev_q;
  wire pl_rise = pl && !pl_prev_q;
  wire wr_fall = !wr_n && wr_prev_q;
  wire [15:0] full_addr = {addr_hi_q, addr_lo_q};
  wire [FW-1:0] faddr = full_addr[FW-1:0];
  wire [EW-1:0] eaddr = full_addr[EW-1:0];
  assign busy = (st_q != ST_IDLE);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ld_prev_q <= 1'b0;
      pl_prev_q <= 1'b0;
      wr_prev_q <= 1'b1;
    end else begin
      ld_prev_q <= ld;
      pl_prev_q <= pl;
      wr_prev_q <= wr_n;
    end
  end

  // command, address and data loading; held until overwritten
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= ppp_pkg::CMD_NOP;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      dlo_q <= 8'h00;
      dhi_q <= 8'h00;
    end else if (ld_rise && !busy) begin
      case (act)
        ppp_pkg::ACT_CMD: cmd_q <= d2_q;
        ppp_pkg::ACT_ADDR: begin
          if (sel_hi) begin
            addr_hi_q <= d2_q;
          end else begin
            addr_lo_q <= d2_q;
          end
        end
        ppp_pkg::ACT_DATA: begin
          if (sel_hi) begin
            dhi_q <= d2_q;
          end else begin
            dlo_q <= d2_q;
          end
        end
        default: ;
      endcase
    end
  end

  // page buffer fill; word position from the low address bits
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fvalid_q <= '0;
      evalid_q <= '0;
    end else if (ld_rise && !busy && act == ppp_pkg::ACT_CMD &&
                 d2_q == ppp_pkg::CMD_NOP) begin
      fvalid_q <= '0;
      evalid_q <= '0;
    end else if (st_q == ST_FLASH && cnt_q == CW'(1)) begin
      fvalid_q <= '0;
    end else if (st_q == ST_EE && cnt_q == CW'(1)) begin
      evalid_q <= '0;
    end else if (pl_rise && !busy) begin
      if (cmd_q == ppp_pkg::CMD_WR_FLASH && sel_hi) begin
        fvalid_q[addr_lo_q[FPW-1:0]] <= 1'b1;
      end else if (cmd_q == ppp_pkg::CMD_WR_EEPROM) begin
        evalid_q[addr_lo_q[EPW-1:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (pl_rise && !busy && cmd_q == ppp_pkg::CMD_WR_FLASH && sel_hi) begin
      fbuf[addr_lo_q[FPW-1:0]] <= {dhi_q, dlo_q};
    end
    if (pl_rise && !busy && cmd_q == ppp_pkg::CMD_WR_EEPROM) begin
      ebuf[addr_lo_q[EPW-1:0]] <= dlo_q;
    end
  end

  // self-timed programming sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      fuse_sel_q <= 2'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (wr_fall) begin
            cnt_q <= CW'(PROG_CYCLES);
            if (cmd_q == ppp_pkg::CMD_WR_FLASH) begin
              st_q <= ST_FLASH;
            end else if (cmd_q == ppp_pkg::CMD_WR_EEPROM && !sel_hi) begin
              st_q <= ST_EE;
            end else if (cmd_q == ppp_pkg::CMD_WR_FUSE) begin
              st_q <= ST_FUSE;
              fuse_sel_q <= {sel_ext, sel_hi};
            end
          end
        end
        default: begin
          if (cnt_q == CW'(1)) begin
            st_q <= ST_IDLE;
          end
          cnt_q <= cnt_q - CW'(1);
        end
      endcase
    end
  end

  // array commits on the last cycle of a program operation
  always_ff @(posedge ref_clk) begin
    if (st_q == ST_FLASH && cnt_q == CW'(1)) begin
      for (int i = 0; i < ppp_pkg::FLASH_PAGE_WORDS; i++) begin
        if (fvalid_q[i]) begin
          flash_mem[{faddr[FW-1:FPW], FPW'(i)}] <= fbuf[i];
        end
      end
    end
    if (st_q == ST_EE && cnt_q == CW'(1)) begin
      for (int i = 0; i < ppp_pkg::EE_PAGE_BYTES; i++) begin
        if (evalid_q[i]) begin
          ee_mem[{eaddr[EW-1:EPW], EPW'(i)}] <= ebuf[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fuse_lo_q <= ppp_pkg::FUSE_LOW_RST;
      fuse_hi_q <= ppp_pkg::FUSE_HIGH_RST;
      fuse_ext_q <= ppp_pkg::FUSE_EXT_RST;
    end else if (st_q == ST_FUSE && cnt_q == CW'(1)) begin
      case (fuse_sel_q)
        2'h1: fuse_hi_q <= dlo_q;
        2'h2: fuse_ext_q <= dlo_q;
        2'h0: fuse_lo_q <= dlo_q;
        default: ;
      endcase
    end
  end

  // read-back and status outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      ready_busy_flag <= 1'b1;
    end else begin
      ready_busy_flag <= !busy;
      data_oe <= !oe_n;
      if (cmd_q == ppp_pkg::CMD_RD_FLASH) begin
        data_out <= sel_hi ? flash_mem[faddr][15:8] : flash_mem[faddr][7:0];
      end else if (cmd_q == ppp_pkg::CMD_RD_EEPROM && !sel_hi) begin
        data_out <= ee_mem[eaddr];
      end else begin
        data_out <= 8'h00;
      end
    end
  end
endmodule

// ===== testbench/ppp_props.sv
/* checker for the programming port: busy timing and bus drive.
   assumes binding to ppp_port, one clock domain. */
`timescale 1ns/10ps
module ppp_props #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic ref_clk, // core clock
  input wire logic resetn, // async reset
  input wire logic write_n, // write pulse
  input wire logic output_enable_n, // output enable
  input wire logic data_oe, // bus drive enable
  input wire logic ready_busy_flag // ready/busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  int cnt_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cnt_q <= 0;
    else if (ready_busy_flag) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
  end
  sequence busy_go;
    $fell(ready_busy_flag);
  endsequence
  sequence quiet;
    (ready_busy_flag && write_n)[*5];
  endsequence
  a_busy_cause: assert property (busy_go |-> !$past(write_n, 3))
    else $error("busy without write pulse");
  a_busy_hold: assert property (busy_go |-> (!ready_busy_flag)[*8])
    else $error("busy too short");
  a_busy_min: assert property ($rose(ready_busy_flag) |-> cnt_q >= PROG_CYCLES - 2)
    else $error("ready returned early");
  a_busy_max: assert property (cnt_q <= PROG_CYCLES + 3)
    else $error("busy too long");
  a_no_spurious: assert property (quiet |=> ready_busy_flag)
    else $error("busy with no write");
  a_reset_idle: assert property ($rose(resetn) |-> ready_busy_flag && !data_oe)
    else $error("bad state after reset");
  a_oe_off: assert property (output_enable_n[*5] |-> !data_oe)
    else $error("bus driven without enable");
  a_oe_release: assert property ($rose(output_enable_n) |-> ##[1:5] !data_oe)
    else $error("bus not released");
endmodule

// ===== testbench/ppp_prog.sv
/* programmer model: drives the port pins, load/latch/write/read tasks.
   assumes the bench clock; resolves the data bus. */
`timescale 1ns/10ps
module ppp_prog (
  input wire logic clk, // core clock
  input wire logic rdy, // ready/busy
  input wire logic [7:0] dout, // device data
  input wire logic doe, // device drive
  output logic [1:0] act, // action code
  output logic sel_hi, // low/high select
  output logic sel_ext, // extended select
  output logic pgl, // page latch
  output logic lds, // load strobe
  output logic wr_n, // write pulse
  output logic oe_n, // output enable
  output logic [7:0] din // resolved bus
);
  logic [7:0] drv;
  logic rel;
  // released bus shows no stale value
  assign din = doe ? dout : (rel ? ~drv : drv);
  initial {act, sel_hi, sel_ext, pgl, lds, wr_n, oe_n, rel, drv} = {2'h3, 6'h03, 1'b0, 8'h00};
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
    {act, sel_hi, drv} = {a, b, d};
    step(4);
    lds = 1'b1;
    step(4);
    lds = 1'b0;
    step(4);
  endtask
  task automatic latch(input logic b);
    sel_hi = b;
    step(4);
    pgl = 1'b1;
    step(4);
    pgl = 1'b0;
    step(4);
  endtask
  task automatic wr(input logic b1, input logic b2, output int n);
    {sel_hi, sel_ext} = {b1, b2};
    step(4);
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(1);
    n = 0;
    // second write pulse and a no-op load while busy, both to be ignored
    while (!rdy && n < 200) begin
      if (n == 1) begin
        {act, drv} = {2'h2, ppp_pkg::CMD_NOP};
      end
      wr_n = !(n >= 5 && n < 9);
      lds = (n >= 5 && n < 9);
      step(1);
      n++;
    end
    wr_n = 1'b1;
    lds = 1'b0;
    {sel_hi, sel_ext} = 2'h0;
    step(4);
  endtask
  task automatic rd(input logic b, output logic [8:0] v);
    {sel_hi, rel, oe_n} = {b, 2'h2};
    step(6);
    v = {doe, din};
    oe_n = 1'b1;
    step(3);
    rel = 1'b0;
    step(3);
  endtask
endmodule

// ===== testbench/tb_top.sv
/* bench for the programming port: flash, eeprom, fuse and read-back.
   assumes ppp_prog as the programmer and the bound checker. */
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn;
  logic [1:0] act;
  localparam int PROG = 20;
  logic sel_hi, sel_ext, pgl, lds, wr_n, oe_n, doe, rdy;
  logic [7:0] din, dout;
  logic [8:0] v;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  always #2 ref_clk = ~ref_clk;
  ppp_port #(.PROG_CYCLES(PROG)) ppp_port_inst (.ref_clk(ref_clk), .resetn(resetn),
    .action_select_hi(act[1]), .action_select_lo(act[0]), .byte_select_low_high(sel_hi),
    .byte_select_extended(sel_ext), .page_latch_strobe(pgl), .load_strobe(lds),
    .write_n(wr_n), .output_enable_n(oe_n), .data_in(din), .data_out(dout),
    .data_oe(doe), .ready_busy_flag(rdy));
  ppp_prog ppp_prog_inst (.clk(ref_clk), .rdy(rdy), .dout(dout), .doe(doe), .act(act),
    .sel_hi(sel_hi), .sel_ext(sel_ext), .pgl(pgl), .lds(lds), .wr_n(wr_n), .oe_n(oe_n),
    .din(din));
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    resetn = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk({7'h00, rdy, doe}, 9'h002);
    resetn = 1'b1;
    ppp_prog_inst.step(4);
    ppp_prog_inst.ld(2'h2, 1'b0, ppp_pkg::CMD_WR_FLASH);
    ppp_prog_inst.ld(2'h0, 1'b1, 8'h01);
    for (int w = 0; w < 2; w++) begin
      ppp_prog_inst.ld(2'h0, 1'b0, 8'h20 | 8'(w * 31));
      ppp_prog_inst.ld(2'h1, 1'b0, 8'h5A ^ 8'(w));
      ppp_prog_inst.ld(2'h1, 1'b1, 8'hC3 ^ 8'(w));
      ppp_prog_inst.latch(1'b1);
    end
    ppp_prog_inst.wr(1'b0, 1'b0, n);
    chk(9'(n >= PROG - 2 && n <= PROG + 1), 9'h001);
    ppp_prog_inst.step(20);
    chk({8'h00, rdy}, 9'h001);
    ppp_prog_inst.ld(2'h2, 1'b0, ppp_pkg::CMD_NOP);
    ppp_prog_inst.ld(2'h2, 1'b0, ppp_pkg::CMD_RD_FLASH);
    for (int w = 0; w < 2; w++) begin
      ppp_prog_inst.ld(2'h0, 1'b0, 8'h20 | 8'(w * 31));
      ppp_prog_inst.rd(1'b0, v);
      chk(v, {1'b1, 8'h5A ^ 8'(w)});
      ppp_prog_inst.rd(1'b1, v);
      chk(v, {1'b1, 8'hC3 ^ 8'(w)});
    end
    chk({8'h00, doe}, 9'h000);
    ppp_prog_inst.ld(2'h2, 1'b0, ppp_pkg::CMD_WR_EEPROM);
    ppp_prog_inst.ld(2'h0, 1'b0, 8'h05);
    ppp_prog_inst.ld(2'h1, 1'b0, 8'hAB);
    ppp_prog_inst.latch(1'b1);
    ppp_prog_inst.wr(1'b0, 1'b0, n);
    chk(9'(n >= PROG - 2 && n <= PROG + 1), 9'h001);
    ppp_prog_inst.ld(2'h2, 1'b0, ppp_pkg::CMD_RD_EEPROM);
    ppp_prog_inst.ld(2'h0, 1'b0, 8'h05);
    ppp_prog_inst.ld(2'h3, 1'b0, ppp_pkg::CMD_WR_FUSE);
    ppp_prog_inst.rd(1'b0, v);
    chk(v, {1'b1, 8'hAB});
    ppp_prog_inst.ld(2'h2, 1'b0, ppp_pkg::CMD_WR_FUSE);
    for (int f = 0; f < 3; f++) begin
      ppp_prog_inst.ld(2'h1, 1'b0, 8'hE2 ^ 8'(f));
      ppp_prog_inst.wr(f == 1, f == 2, n);
      chk(9'(n >= PROG - 2 && n <= PROG + 1), 9'h001);
    end
    chk({1'b0, ppp_port_inst.fuse_lo_q}, 9'h0E2);
    chk({1'b0, ppp_port_inst.fuse_hi_q}, 9'h0E3);
    chk({1'b0, ppp_port_inst.fuse_ext_q}, 9'h0E0);
    complete_run();
  end
endmodule
bind ppp_port ppp_props #(.PROG_CYCLES(PROG_CYCLES)) ppp_props_inst (.ref_clk, .resetn,
  .write_n, .output_enable_n, .data_oe, .ready_busy_flag);
